// ==== common/exc_seq_pkg.sv ====
package exc_seq_pkg;
    // Vector numbers; slot address is number times four
    localparam logic [5:0] VEC_RESET     = 6'h00;
    localparam logic [5:0] VEC_NMI       = 6'h07;
    localparam logic [5:0] VEC_TRAP_BASE = 6'h08;
    localparam logic [5:0] VEC_TRAP_LAST = 6'h0b;
    localparam logic [5:0] VEC_EXT_BASE  = 6'h0c;
    localparam logic [5:0] VEC_INT_BASE  = 6'h14;
    localparam logic [5:0] VEC_INT_LAST  = 6'h3c;
    localparam int         N_EXT         = 8;
    localparam int         N_INT         = 34;
    localparam int         VEC_SHIFT     = 2;
    // Condition flag bit positions
    localparam int         CCR_I_BIT     = 7;
    localparam int         CCR_UI_BIT    = 6;
    // Reset values
    localparam logic       UFS_RESET     = 1'b1;
    localparam logic [7:0] CCR_RESET     = 8'h80;
    // Least low time of the init input
    localparam int         RST_MIN_CYC   = 10;
    localparam int         RST_PWRUP_MS  = 20;
    // Stack frame: PC and flags pushed as two words
    localparam logic [23:0] STACK_STEP   = 24'h000002;
endpackage

// ==== verilog/exc_prio_pick.sv ====
`timescale 1ns/10ps
// Picks the winning maskable interrupt: high level first, then lowest index
module exc_prio_pick #(
    parameter int N = 42
) (
    // Requests and levels
    input  wire logic [N-1:0] i_req,
    input  wire logic [N-1:0] i_hi,
    // Result
    output logic              o_any,
    output logic [5:0]        o_idx
);
    logic [N-1:0] hi_req;
    logic         hi_any;
    logic [5:0]   hi_idx;
    logic [5:0]   lo_idx;

    assign hi_req = i_req & i_hi;

    always_comb begin
        hi_any = 1'b0;
        hi_idx = 6'h00;
        lo_idx = 6'h00;
        for (int k = N - 1; k >= 0; k--) begin
            if (hi_req[k]) begin
                hi_any = 1'b1;
                hi_idx = 6'(k);
            end
            if (i_req[k]) begin
                lo_idx = 6'(k);
            end
        end
    end

    assign o_any = |i_req;
    assign o_idx = hi_any ? hi_idx : lo_idx;
endmodule

// ==== verilog/cpu_exception_sequencer.sv ====
`timescale 1ns/10ps
module cpu_exception_sequencer #(
    parameter int N_EXT_P = exc_seq_pkg::N_EXT,
    parameter int N_INT_P = exc_seq_pkg::N_INT
) (
    // Clock and reset
    input  wire logic                       i_clk,
    input  wire logic                       i_rst_n,
    // Chip init pin and watchdog
    input  wire logic                       i_chip_init_input_n,
    input  wire logic                       i_wdt_overflow,
    // Interrupt sources
    input  wire logic                       i_nmi_req,
    input  wire logic [N_EXT_P-1:0]         i_external_request_lines,
    input  wire logic [N_INT_P-1:0]         i_int_req,
    input  wire logic [N_EXT_P+N_INT_P-1:0] i_prio_level,
    input  wire logic                       i_user_flag_select,
    // Core handshake
    input  wire logic                       i_insn_boundary,
    input  wire logic                       i_software_trap_op,
    input  wire logic [1:0]                 i_trap_num,
    input  wire logic [23:0]                i_pc,
    input  wire logic [23:0]                i_sp,
    input  wire logic [7:0]                 i_cond_flags_word,
    // Memory bus
    output logic                            o_mem_req,
    output logic                            o_mem_we,
    output logic                            o_mem_long,
    output logic [23:0]                     o_mem_addr,
    output logic [31:0]                     o_mem_wdata,
    input  wire logic                       i_mem_ack,
    input  wire logic [31:0]                i_mem_rdata,
    // Results to core
    output logic                            o_core_hold,
    output logic                            o_load_pc,
    output logic [23:0]                     o_new_pc,
    output logic [23:0]                     o_new_sp,
    output logic [7:0]                      o_new_cond_flags_word,
    output logic                            o_int_ack,
    output logic [5:0]                      o_vec_num
);
    localparam int NM = N_EXT_P + N_INT_P;
    localparam logic [23:0] WORD_MASK = 24'hfffffe;

    typedef enum logic [2:0] {
        ST_RESET, ST_IDLE, ST_PUSH_PC, ST_PUSH_CCR, ST_FETCH, ST_LOAD
    } state_e;

    typedef struct packed {
        state_e      st;
        logic        init_s1;
        logic        init_s2;
        logic        nmi_s1;
        logic        nmi_s2;
        logic        nmi_d;
        logic        nmi_pend;
        logic [NM-1:0] mreq_s1;
        logic [NM-1:0] mreq_s2;
        logic        first_done;
        logic        seen_insn;
        logic        req;
        logic        we;
        logic        lng;
        logic [23:0] addr;
        logic [31:0] wdata;
        logic [23:0] sp;
        logic [7:0]  cond_flags_word;
        logic [23:0] new_pc;
        logic        load_pc;
        logic        ack;
        logic [5:0]  vec;
    } state_s;

    state_s       cur_r;
    state_s       cur_nxt;
    logic         pick_any;
    logic [5:0]   pick_idx;
    logic         masked;
    logic         int_ok;
    logic         init_low;
    logic          ui_masks;
    logic [NM-1:0] live_req;
    logic [7:0]   masked_ccr;
    logic         nmi_edge;
    logic         first_bnd;
    logic         take_nmi;
    logic         take_irq;
    logic         take_trap;
    logic         frame_start;
    logic [5:0]   irq_vec;
    logic [5:0]   trap_vec;
    logic [23:0]  push_pc_sp;
    logic [23:0]  push_ccr_sp;
    logic [23:0]  push_pc_addr;
    logic [23:0]  push_ccr_addr;
    logic [31:0]  push_pc_data;
    logic [31:0]  push_ccr_data;
    logic [23:0]  vec_addr;
    logic [23:0]  reset_addr;

    exc_prio_pick #(
        .N (NM)
    ) u_pick (
        .i_req (live_req),
        .i_hi  (i_prio_level),
        .o_any (pick_any),
        .o_idx (pick_idx)
    );

    // I masks everything maskable; UI masks low level only when select is 0
    assign masked   = cur_r.cond_flags_word[exc_seq_pkg::CCR_I_BIT];
    assign ui_masks = !i_user_flag_select && cur_r.cond_flags_word[exc_seq_pkg::CCR_UI_BIT];

    // Masking per source, so a masked low request cannot hide a live one
    generate
        for (genvar g = 0; g < NM; g++) begin : g_mask
            assign live_req[g] = cur_r.mreq_s2[g]
                && !(ui_masks && !i_prio_level[g]);
        end
    endgenerate

    // Mask bits an accepted trap or interrupt leaves behind
    always_comb begin
        masked_ccr = cur_r.cond_flags_word;
        masked_ccr[exc_seq_pkg::CCR_I_BIT] = 1'b1;
        if (!i_user_flag_select) begin
            masked_ccr[exc_seq_pkg::CCR_UI_BIT] = 1'b1;
        end
    end

    assign init_low = !cur_r.init_s2 || i_wdt_overflow;
    assign int_ok   = cur_r.first_done && i_insn_boundary;

    // Synced nonmaskable line, rising edge only
    assign nmi_edge = cur_r.nmi_s2 && !cur_r.nmi_d;

    // Second boundary after the reset vector load ends the first instruction
    assign first_bnd = !cur_r.first_done && cur_r.seen_insn && i_insn_boundary;

    // Acceptance in idle: nonmaskable, then maskable, then trap
    assign take_nmi    = int_ok && cur_r.nmi_pend;
    assign take_irq    = int_ok && !cur_r.nmi_pend && pick_any && !masked;
    assign take_trap   = !take_nmi && !take_irq && i_software_trap_op;
    assign frame_start = take_nmi || take_irq || take_trap;
    assign irq_vec     = exc_seq_pkg::VEC_EXT_BASE + pick_idx;
    assign trap_vec    = exc_seq_pkg::VEC_TRAP_BASE + {4'h0, i_trap_num};

    // Word pushes step the stack by two with bit zero forced low
    assign push_pc_sp    = i_sp - exc_seq_pkg::STACK_STEP;
    assign push_ccr_sp   = cur_r.sp - exc_seq_pkg::STACK_STEP;
    assign push_pc_addr  = push_pc_sp & WORD_MASK;
    assign push_ccr_addr = push_ccr_sp & WORD_MASK;
    assign push_pc_data  = {16'h0000, i_pc[15:0]};
    assign push_ccr_data = {16'h0000, cur_r.cond_flags_word, i_pc[23:16]};

    // Vector slot: number times four, upper bits zero
    assign vec_addr   = {16'h0000, cur_r.vec, 2'b00};
    assign reset_addr = {16'h0000, exc_seq_pkg::VEC_RESET, 2'b00};

    always_comb begin
        cur_nxt         = cur_r;
        cur_nxt.init_s1 = i_chip_init_input_n;
        cur_nxt.init_s2 = cur_r.init_s1;
        cur_nxt.nmi_s1  = i_nmi_req;
        cur_nxt.nmi_s2  = cur_r.nmi_s1;
        cur_nxt.nmi_d   = cur_r.nmi_s2;
        cur_nxt.mreq_s1 = {i_int_req, i_external_request_lines};
        cur_nxt.mreq_s2 = cur_r.mreq_s1;
        cur_nxt.ack     = 1'b0;
        cur_nxt.load_pc = 1'b0;
        // Edge capture so a short nonmaskable pulse is not lost
        if (nmi_edge) begin
            cur_nxt.nmi_pend = 1'b1;
        end
        if (first_bnd) begin
            cur_nxt.first_done = 1'b1;
        end

        case (cur_r.st)
            ST_RESET: begin
                // Held here while init is low; rising edge starts handling
                if (cur_r.init_s2) begin
                    cur_nxt.cond_flags_word   = exc_seq_pkg::CCR_RESET;
                    cur_nxt.vec   = exc_seq_pkg::VEC_RESET;
                    cur_nxt.st    = ST_FETCH;
                    cur_nxt.req   = 1'b1;
                    cur_nxt.we    = 1'b0;
                    cur_nxt.lng   = 1'b1;
                    cur_nxt.addr  = reset_addr;
                end
            end

            ST_IDLE: begin
                cur_nxt.cond_flags_word = i_cond_flags_word;
                cur_nxt.sp  = i_sp;
                if (!cur_r.seen_insn && i_insn_boundary) begin
                    cur_nxt.seen_insn = 1'b1;
                end
                if (take_nmi) begin
                    cur_nxt.vec      = exc_seq_pkg::VEC_NMI;
                    // A fresh edge in the same cycle stays pending: set wins
                    cur_nxt.nmi_pend = nmi_edge;
                    cur_nxt.ack      = 1'b1;
                    cur_nxt.st       = ST_PUSH_PC;
                end else if (take_irq) begin
                    cur_nxt.vec = irq_vec;
                    cur_nxt.ack = 1'b1;
                    cur_nxt.st  = ST_PUSH_PC;
                end else if (take_trap) begin
                    cur_nxt.vec = trap_vec;
                    cur_nxt.st  = ST_PUSH_PC;
                end
                if (frame_start) begin
                    cur_nxt.req   = 1'b1;
                    cur_nxt.we    = 1'b1;
                    cur_nxt.lng   = 1'b0;
                    cur_nxt.addr  = push_pc_addr;
                    cur_nxt.sp    = push_pc_sp;
                    cur_nxt.wdata = push_pc_data;
                end
            end

            ST_PUSH_PC: begin
                if (i_mem_ack) begin
                    cur_nxt.addr  = push_ccr_addr;
                    cur_nxt.sp    = push_ccr_sp;
                    // Flags in the high byte, upper PC bits below
                    cur_nxt.wdata = push_ccr_data;
                    cur_nxt.st    = ST_PUSH_CCR;
                end
            end

            ST_PUSH_CCR: begin
                if (i_mem_ack) begin
                    cur_nxt.cond_flags_word  = masked_ccr;
                    cur_nxt.we   = 1'b0;
                    cur_nxt.lng  = 1'b1;
                    cur_nxt.addr = vec_addr;
                    cur_nxt.st   = ST_FETCH;
                end
            end

            ST_FETCH: begin
                if (i_mem_ack) begin
                    cur_nxt.req     = 1'b0;
                    cur_nxt.new_pc  = i_mem_rdata[23:0];
                    cur_nxt.load_pc = 1'b1;
                    cur_nxt.st      = ST_LOAD;
                end
            end

            ST_LOAD: begin
                cur_nxt.st = ST_IDLE;
            end

            default: begin
                cur_nxt.st = ST_RESET;
            end
        endcase

        // Init low wins over everything and restarts the sequence
        if (init_low) begin
            cur_nxt.st         = ST_RESET;
            cur_nxt.req        = 1'b0;
            cur_nxt.we         = 1'b0;
            cur_nxt.first_done = 1'b0;
            cur_nxt.seen_insn  = 1'b0;
            cur_nxt.nmi_pend   = 1'b0;
            cur_nxt.ack        = 1'b0;
            cur_nxt.load_pc    = 1'b0;
            cur_nxt.cond_flags_word        = exc_seq_pkg::CCR_RESET;
            cur_nxt.vec        = exc_seq_pkg::VEC_RESET;
            cur_nxt.lng        = 1'b0;
            if (i_wdt_overflow) begin
                cur_nxt.init_s2 = 1'b0;
                cur_nxt.init_s1 = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cur_r <= '0;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    // Bus request straight from the state flops
    assign o_mem_req             = cur_r.req;
    assign o_mem_we              = cur_r.we;
    assign o_mem_long            = cur_r.lng;
    assign o_mem_addr            = cur_r.addr;
    assign o_mem_wdata           = cur_r.wdata;

    // Core side; hold is the only combinational output
    assign o_core_hold           = (cur_r.st != ST_IDLE);
    assign o_load_pc             = cur_r.load_pc;
    assign o_new_pc              = cur_r.new_pc;
    assign o_new_sp              = cur_r.sp;
    assign o_new_cond_flags_word = cur_r.cond_flags_word;
    assign o_int_ack             = cur_r.ack;
    assign o_vec_num             = cur_r.vec;
endmodule

// ==== test/cpu_exception_sequencer_sva.sv ====
`timescale 1ns/10ps
module exc_seq_checker (
    // Clock, reset, init pin
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic        i_chip_init_input_n,
    // Bus and core results
    input wire logic        i_mem_ack,
    input wire logic        o_mem_req,
    input wire logic        o_mem_we,
    input wire logic        o_mem_long,
    input wire logic [23:0] o_mem_addr,
    input wire logic        o_load_pc,
    input wire logic        o_int_ack
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    property p_req_hold; o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr); endproperty
    a_req_hold: assert property (p_req_hold) else $error("bus request dropped early");
    property p_push_even; o_mem_req && o_mem_we |-> !o_mem_addr[0] && !o_mem_long; endproperty
    a_push_even: assert property (p_push_even) else $error("odd or long push");
    property p_vec_slot;
        o_mem_req && !o_mem_we |-> o_mem_long && o_mem_addr[1:0] == 2'h0
            && o_mem_addr[23:8] == 16'h0000
            && (o_mem_addr[7:2] == 6'h00 || o_mem_addr[7:2] inside {[6'h07:6'h3c]});
    endproperty
    a_vec_slot: assert property (p_vec_slot) else $error("bad vector slot");
    property p_load_fetch; o_mem_req && i_mem_ack && !o_mem_we |-> ##[1:2] o_load_pc; endproperty
    a_load_fetch: assert property (p_load_fetch) else $error("no pc load");
    property p_init_halt; !i_chip_init_input_n [*4] |-> !o_mem_req && !o_int_ack; endproperty
    a_init_halt: assert property (p_init_halt) else $error("activity in init");
    property p_init_rise;
        $rose(i_chip_init_input_n) |-> ##[1:6] (o_mem_req && !o_mem_we && o_mem_addr == 24'h000000);
    endproperty
    a_init_rise: assert property (p_init_rise) else $error("no reset fetch");
    property p_no_push; o_mem_req && !o_mem_we && o_mem_addr == 24'h000000 |-> !$past(o_mem_we); endproperty
    a_no_push: assert property (p_no_push) else $error("push before reset fetch");
    property p_int_push; o_int_ack |-> ##[0:2] (o_mem_req && o_mem_we); endproperty
    a_int_push: assert property (p_int_push) else $error("no push after accept");
endmodule

bind cpu_exception_sequencer exc_seq_checker u_chk (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_chip_init_input_n(i_chip_init_input_n),
    .i_mem_ack(i_mem_ack), .o_mem_req(o_mem_req), .o_mem_we(o_mem_we), .o_mem_long(o_mem_long),
    .o_mem_addr(o_mem_addr), .o_load_pc(o_load_pc), .o_int_ack(o_int_ack)
);

// ==== test/mem_partner.sv ====
`timescale 1ns/10ps
module mem_partner (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // Bus from the sequencer
    input  wire logic        i_req,
    input  wire logic [23:0] i_addr,
    input  wire logic        i_slow,
    output logic             o_ack,
    output logic [31:0]      o_rdata
);
    logic [1:0] wait_r;
    // Data outside ack toggles so a late sample cannot pass
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ack   <= 1'b0;
            wait_r  <= 2'h0;
            o_rdata <= 32'h00000000;
        end else if (i_req && !o_ack && (!i_slow || wait_r == 2'h3)) begin
            o_ack   <= 1'b1;
            wait_r  <= 2'h0;
            o_rdata <= {8'ha5, i_addr ^ 24'h3c0000};
        end else begin
            o_ack   <= 1'b0;
            wait_r  <= (i_req && !o_ack) ? wait_r + 2'h1 : 2'h0;
            o_rdata <= ~o_rdata;
        end
    end
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
    logic        i_clk = 1'b0, i_rst_n = 1'b0, pin_n = 1'b0, wdt = 1'b0, nmi = 1'b0;
    logic        sel = 1'b1, bnd = 1'b0, trap = 1'b0, slow = 1'b0;
    logic        req, we, lng, ld, ack, iack, hold;
    logic [1:0]  tnum = 2'h0;
    logic [7:0]  ext = 8'h00, cond_flags_word = 8'h00, nccr;
    logic [33:0] intr = 34'h0;
    logic [41:0] prio = 42'h0;
    logic [23:0] pc = 24'h000000, sp = 24'h000000, addr, npc;
    logic [31:0] rdat, wdat, seed = 32'h7713e36c;
    logic [5:0]  vnum;
    logic [57:0] mq[$];
    logic [45:0] pq[$];
    int          mismatches = 0, n_tests = 0, acks = 0;

    always #20 i_clk = ~i_clk;

    cpu_exception_sequencer u_dut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_chip_init_input_n(pin_n), .i_wdt_overflow(wdt),
        .i_nmi_req(nmi), .i_external_request_lines(ext), .i_int_req(intr), .i_prio_level(prio),
        .i_user_flag_select(sel), .i_insn_boundary(bnd), .i_software_trap_op(trap),
        .i_trap_num(tnum), .i_pc(pc), .i_sp(sp), .i_cond_flags_word(cond_flags_word),
        .o_mem_req(req), .o_mem_we(we), .o_mem_long(lng), .o_mem_addr(addr), .o_mem_wdata(wdat),
        .i_mem_ack(ack), .i_mem_rdata(rdat), .o_core_hold(hold), .o_load_pc(ld),
        .o_new_pc(npc), .o_new_sp(), .o_new_cond_flags_word(nccr), .o_int_ack(iack),
        .o_vec_num(vnum)
    );
    mem_partner u_mem (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(req), .i_addr(addr), .i_slow(slow),
        .o_ack(ack), .o_rdata(rdat)
    );

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic fail(input logic ok);
        n_tests++;
        if (!ok) begin
            mismatches++;
            $display("ERROR %0t result mismatch", $time);
        end
    endtask
    task automatic cmp_mem(input logic [57:0] got, input logic [57:0] exp);
        fail(got === exp);
    endtask
    task automatic cmp_load(input logic [23:0] gpc, input logic [5:0] gv,
                            input logic [7:0] gf, input logic [45:0] e);
        fail({gpc, gv, gf & e[7:0]} === e[45:8]);
    endtask
    task automatic cmp_cnt(input int got, input int exp);
        fail(got == exp);
    endtask
    task automatic print_verdict();
        if (mismatches == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge i_clk) begin
        if (req === 1'b1 && ack === 1'b1) begin
            cmp_mem({we, lng, addr, we ? wdat : 32'h00000000},
                    mq.size() > 0 ? mq.pop_front() : {58{1'b1}});
        end
        if (ld === 1'b1) begin
            cmp_load(npc, vnum, nccr, pq.size() > 0 ? pq.pop_front() : {46{1'b1}});
        end
        if (iack === 1'b1) begin
            acks++;
        end
    end

    task automatic expect_frame(input logic push, input logic [5:0] v,
                                input logic [7:0] e, input logic [7:0] m);
        if (push) begin
            mq.push_back({2'h2, (sp - 24'h000002) & 24'hfffffe, 16'h0000, pc[15:0]});
            mq.push_back({2'h2, (sp - 24'h000004) & 24'hfffffe, 16'h0000, cond_flags_word, pc[23:16]});
        end
        mq.push_back({2'h1, 16'h0000, v, 2'h0, 32'h00000000});
        pq.push_back({{16'h0000, v, 2'h0} ^ 24'h3c0000, v, e, m});
    endtask
    task automatic wait_done();
        for (int k = 0; k < 300 && pq.size() != 0; k++) @(negedge i_clk);
        cmp_cnt(mq.size() + pq.size(), 0);
    endtask
    task automatic new_state();
        logic [31:0] r;
        @(negedge i_clk);
        r = xs();
        pc = r[23:0];
        slow = r[31];
        r = xs();
        sp = {4'h0, r[19:0]};
    endtask
    task automatic refused(input int cyc);
        int a0;
        a0 = acks;
        repeat (cyc) @(negedge i_clk);
        cmp_cnt(acks, a0);
    endtask
    task automatic run_int(input logic [5:0] v);
        expect_frame(1'b1, v, 8'h80, 8'h80);
        bnd = 1'b1;
        for (int k = 0; k < 60 && iack !== 1'b1; k++) @(negedge i_clk);
        bnd = 1'b0;
        ext = 8'h00;
        intr = 34'h0;
        nmi = 1'b0;
        wait_done();
    endtask
    task automatic run_trap(input logic [1:0] n);
        new_state();
        cond_flags_word = seed[7:0];
        sel = n[0];
        tnum = n;
        trap = 1'b1;
        expect_frame(1'b1, 6'h08 + {4'h0, n}, {1'b1, n[0] ? cond_flags_word[6] : 1'b1, 6'h00}, 8'hc0);
        for (int k = 0; k < 60 && hold !== 1'b1; k++) @(negedge i_clk);
        trap = 1'b0;
        wait_done();
    endtask

    initial begin
        repeat (2) @(negedge i_clk);
        i_rst_n = 1'b1;
        ext = 8'h01;
        repeat (10) @(negedge i_clk); // Power-up hold shortened
        expect_frame(1'b0, 6'h00, 8'h80, 8'h80);
        pin_n = 1'b1;
        wait_done();
        refused(8);
        run_int(6'h0c);
        for (int n = 0; n < 4; n++) run_trap(n[1:0]);
        new_state();
        cond_flags_word = 8'h80;
        ext = 8'h20;
        bnd = 1'b1;
        refused(12);
        nmi = 1'b1;
        run_int(6'h07);
        new_state();
        cond_flags_word = 8'h40;
        sel = 1'b0;
        ext = 8'h02;
        bnd = 1'b1;
        refused(12);
        prio = 42'h002;
        run_int(6'h0d);
        new_state();
        cond_flags_word = 8'h00;
        sel = 1'b1;
        ext = 8'h08;
        intr = 34'h4;
        prio = 42'h400;
        run_int(6'h16);
        new_state();
        ext = 8'h08;
        run_int(6'h0f);
        new_state();
        pin_n = 1'b0;
        expect_frame(1'b0, 6'h00, 8'h80, 8'h80);
        repeat (10) @(negedge i_clk); // Least running hold
        pin_n = 1'b1;
        wait_done();
        refused(4);
        new_state();
        wdt = 1'b1;
        expect_frame(1'b0, 6'h00, 8'h80, 8'h80);
        @(negedge i_clk);
        wdt = 1'b0;
        wait_done();
        print_verdict();
    end

    initial begin
        repeat (4000) @(posedge i_clk);
        mismatches++;
        print_verdict();
    end
endmodule
